// ===== verilog/cla_top.sv
// Top: AHB-Lite registers, rate source select, command, feedback scaling, protection
// Assumes one AHB-Lite master, zero-wait slave, all inputs synchronous to ref_clk_i
`timescale 1ns/1ns
module cla_top #(
    parameter int unsigned FB_W = 12
) (
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            sys_rst_i,
    // AHB-Lite slave
    input  wire logic            hsel_i,
    input  wire logic [31:0]     haddr_i,
    input  wire logic [1:0]      htrans_i,
    input  wire logic            hwrite_i,
    input  wire logic [2:0]      hsize_i,
    input  wire logic [31:0]     hwdata_i,
    input  wire logic            hready_i,
    output logic                 hreadyout_o,
    output logic                 hresp_o,
    output logic [31:0]          hrdata_o,
    // Rate pin, as converted level and as raw pulse
    input  wire logic [8:0]      rate_level_i,
    input  wire logic            rate_pulse_i,
    // Motor feedback
    input  wire logic [FB_W-1:0] phase_current_i,
    input  wire logic [8:0]      bemf_amp_i,
    input  wire logic            overcurrent_i,
    // Drive outputs
    output logic [8:0]           drive_amplitude_o,
    output logic [17:0]          advance_cycles_o,
    output logic [FB_W-1:0]      loop_feedback_o,
    output logic                 drive_enable_o
);
    cla_ctl_if ctl ();

    logic [7:0]                    ctrl;
    logic [7:0]                    next_ctrl;
    logic                          host_rate_high;
    logic                          next_host_rate_high;
    logic [8:0]                    host_rate_command;
    logic [8:0]                    next_host_rate_command;
    logic [6:0]                    advance_time_code;
    logic [6:0]                    next_advance_time_code;
    logic                          dp_write;
    logic                          next_dp_write;
    logic [7:0]                    dp_addr;
    logic [7:0]                    next_dp_addr;
    logic [31:0]                   rdata;
    logic [31:0]                   next_rdata;
    logic [cla_pkg::PWM_CNT_W-1:0] win_cnt;
    logic [cla_pkg::PWM_CNT_W-1:0] next_win_cnt;
    logic [cla_pkg::PWM_CNT_W-1:0] hi_cnt;
    logic [cla_pkg::PWM_CNT_W-1:0] next_hi_cnt;
    logic [8:0]                    pulse_duty;
    logic [8:0]                    next_pulse_duty;
    logic [8:0]                    target;
    logic [8:0]                    next_target;
    logic [FB_W-1:0]               feedback;
    logic [FB_W-1:0]               next_feedback;
    logic                          drive_en;
    logic                          next_drive_en;
    logic                          addr_valid;
    logic                          host_command_select;
    logic                          rate_input_mode;
    logic [1:0]                    feedback_attenuation;

    function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [7:0] c,
                                             input logic h, input logic [8:0] l,
                                             input logic [6:0] adc, input logic [8:0] e,
                                             input logic [8:0] t, input logic [17:0] adv,
                                             input logic oc);
        case (a)
            cla_pkg::OFS_CTRL:        read_mux = {24'h000000, c};
            cla_pkg::OFS_RATE_LOW:    read_mux = {24'h000000, l[7:0]};
            cla_pkg::OFS_RATE_HIGH:   read_mux = {31'h00000000, h};
            cla_pkg::OFS_ADV_CODE:    read_mux = {25'h0000000, adc};
            cla_pkg::OFS_STATUS:      read_mux = {7'h00, t, 7'h00, e};
            cla_pkg::OFS_ADV_STATUS:  read_mux = {14'h0000, adv};
            cla_pkg::OFS_PROT_STATUS: read_mux = {31'h00000000, oc};
            default:                  read_mux = 32'h00000000;
        endcase
    endfunction

    assign host_command_select  = ctrl[cla_pkg::CTRL_HOST_SEL];
    assign rate_input_mode      = ctrl[cla_pkg::CTRL_INPUT_MODE];
    assign feedback_attenuation = ctrl[cla_pkg::CTRL_ATTEN_LSB +: 2];
    assign addr_valid           = hsel_i && htrans_i[1] && hready_i;

    always_comb begin
        next_ctrl              = ctrl;
        next_host_rate_high    = host_rate_high;
        next_host_rate_command = host_rate_command;
        next_advance_time_code = advance_time_code;
        next_dp_write          = addr_valid && hwrite_i;
        next_dp_addr           = addr_valid ? haddr_i[7:0] : dp_addr;
        next_rdata             = rdata;
        if (addr_valid && !hwrite_i) begin
            next_rdata = read_mux(haddr_i[7:0], ctrl, host_rate_high, host_rate_command,
                                  advance_time_code, ctl.effective, target,
                                  ctl.adv_cycles, !drive_en);
        end
        if (dp_write) begin
            case (dp_addr)
                cla_pkg::OFS_CTRL:      next_ctrl = hwdata_i[7:0];
                cla_pkg::OFS_RATE_HIGH: next_host_rate_high = hwdata_i[0];
                cla_pkg::OFS_RATE_LOW:  next_host_rate_command = {host_rate_high,
                                                                  hwdata_i[7:0]};
                cla_pkg::OFS_ADV_CODE:  next_advance_time_code = hwdata_i[6:0];
                default:                next_ctrl = ctrl;
            endcase
        end
    end

    always_comb begin
        next_win_cnt    = win_cnt + 1'b1;
        next_hi_cnt     = hi_cnt + {{(cla_pkg::PWM_CNT_W-1){1'b0}}, rate_pulse_i};
        next_pulse_duty = pulse_duty;
        if (win_cnt == cla_pkg::PWM_CNT_W'(cla_pkg::PWM_WIN_CYC - 1)) begin
            // Latch the window's count, last cycle included, before clearing it
            next_pulse_duty = (next_hi_cnt > cla_pkg::PWM_CNT_W'(cla_pkg::CMD_FULL_SCALE))
                              ? cla_pkg::CMD_FULL_SCALE : next_hi_cnt[8:0];
            next_win_cnt    = '0;
            next_hi_cnt     = '0;
        end
        if (host_command_select) begin
            next_target = host_rate_command;
        end else if (rate_input_mode) begin
            next_target = pulse_duty;
        end else begin
            next_target = rate_level_i;
        end
        next_feedback = phase_current_i >> feedback_attenuation;
        next_drive_en = !overcurrent_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl              <= cla_pkg::CTRL_RESET;
            host_rate_high    <= 1'b0;
            host_rate_command <= cla_pkg::RATE_RESET;
            advance_time_code <= cla_pkg::ADV_CODE_RESET;
            dp_write          <= 1'b0;
            dp_addr           <= 8'h00;
            rdata             <= 32'h00000000;
            win_cnt           <= '0;
            hi_cnt            <= '0;
            pulse_duty        <= cla_pkg::RATE_RESET;
            target            <= cla_pkg::RATE_RESET;
            feedback          <= '0;
            drive_en          <= 1'b0;
        end else begin
            ctrl              <= next_ctrl;
            host_rate_high    <= next_host_rate_high;
            host_rate_command <= next_host_rate_command;
            advance_time_code <= next_advance_time_code;
            dp_write          <= next_dp_write;
            dp_addr           <= next_dp_addr;
            rdata             <= next_rdata;
            win_cnt           <= next_win_cnt;
            hi_cnt            <= next_hi_cnt;
            pulse_duty        <= next_pulse_duty;
            target            <= next_target;
            feedback          <= next_feedback;
            drive_en          <= next_drive_en;
        end
    end

    // Carrier to the workers
    assign ctl.target   = target;
    assign ctl.slew_sel = ctrl[cla_pkg::CTRL_SLEW_LSB +: 3];
    assign ctl.adv_code = advance_time_code;
    assign ctl.adv_mode = ctrl[cla_pkg::CTRL_ADV_MODE];
    assign ctl.bemf_amp = bemf_amp_i;

    cla_slew u_slew (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .ctl       (ctl)
    );

    cla_advance u_advance (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .ctl       (ctl)
    );

    // Outputs
    assign hreadyout_o       = 1'b1;
    assign hresp_o           = 1'b0;
    assign hrdata_o          = rdata;
    assign drive_amplitude_o = ctl.effective;
    assign advance_cycles_o  = ctl.adv_cycles;
    assign loop_feedback_o   = feedback;
    assign drive_enable_o    = drive_en;

    sequence s_high_write;
        dp_write && dp_addr == cla_pkg::OFS_RATE_HIGH;
    endsequence

    host_pin_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        host_command_select |=> target == $past(host_rate_command))
        else $error("Target not taken from host command");
    high_hold_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        s_high_write |=> host_rate_command == $past(host_rate_command))
        else $error("High bit write changed applied command");
    low_apply_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (dp_write && dp_addr == cla_pkg::OFS_RATE_LOW) |=>
        host_rate_command == {$past(host_rate_high), $past(hwdata_i[7:0])})
        else $error("Low byte write did not apply full command");
    atten_fb_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        1'b1 |=> feedback == ($past(phase_current_i) >> $past(feedback_attenuation)))
        else $error("Feedback not attenuated by field");
    oc_cut_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        overcurrent_i |=> !drive_enable_o)
        else $error("Drive not cut on overcurrent");
    pin_mode_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!host_command_select && !rate_input_mode) |=> target == $past(rate_level_i))
        else $error("Level mode target not from pin");
endmodule // cla_top

// ===== verilog/cla_pkg.sv
// Package: shared constants of the closed-loop rate and advance logic
// Assumes a 25 MHz clock and a single AHB-Lite master
package cla_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 40;
    // Advance time step, in ns, and in half clock cycles (2.5 us is 62.5 cycles)
    localparam int unsigned ADV_UNIT_NS      = 2500;
    localparam int unsigned ADV_UNIT_HALF    = (2 * ADV_UNIT_NS) / CLK_PERIOD_NS;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL         = 8'h00;
    localparam logic [7:0]  OFS_RATE_LOW     = 8'h04;
    localparam logic [7:0]  OFS_RATE_HIGH    = 8'h08;
    localparam logic [7:0]  OFS_ADV_CODE     = 8'h0c;
    localparam logic [7:0]  OFS_STATUS       = 8'h10;
    localparam logic [7:0]  OFS_ADV_STATUS   = 8'h14;
    localparam logic [7:0]  OFS_PROT_STATUS  = 8'h18;
    // Control and status register field positions
    localparam int unsigned CTRL_HOST_SEL    = 0;
    localparam int unsigned CTRL_INPUT_MODE  = 1;
    localparam int unsigned CTRL_ADV_MODE    = 2;
    localparam int unsigned CTRL_SLEW_LSB    = 3;
    localparam int unsigned CTRL_ATTEN_LSB   = 6;
    localparam int unsigned STAT_TARGET_LSB  = 16;
    // Reset values
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [6:0]  ADV_CODE_RESET   = 7'h00;
    localparam logic [8:0]  RATE_RESET       = 9'h000;
    // Command width and full scale
    localparam int unsigned CMD_W            = 9;
    localparam logic [8:0]  CMD_FULL_SCALE   = 9'h1ff;
    // Slew step interval at the fastest setting (field 7), in cycles, doubled per step of the field below 7
    localparam int unsigned SLEW_BASE_CYC    = 16;
    localparam int unsigned SLEW_CNT_W       = 12;
    // Pulse-width measurement window in cycles
    localparam int unsigned PWM_WIN_CYC      = 512;
    localparam int unsigned PWM_CNT_W        = 10;
    localparam int unsigned ADV_W            = 18;
endpackage

// ===== verilog/cla_ctl_if.sv
// Interface: command and advance signals between the top and its two workers
// Assumes all members are driven in the ref_clk_i domain
`timescale 1ns/1ns
interface cla_ctl_if;
    logic [8:0]  target;
    logic [2:0]  slew_sel;
    logic [8:0]  effective;
    logic [6:0]  adv_code;
    logic        adv_mode;
    logic [8:0]  bemf_amp;
    logic [17:0] adv_cycles;

    modport top (output target, slew_sel, adv_code, adv_mode, bemf_amp,
                 input  effective, adv_cycles);
    modport slew (input target, slew_sel, output effective);
    modport adv  (input effective, adv_code, adv_mode, bemf_amp, output adv_cycles);
endinterface

// ===== verilog/cla_slew.sv
// Slew limiter: walks the effective command toward the target one step per interval
// Assumes synchronous active-high reset
`timescale 1ns/1ns
module cla_slew (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    // Command carrier
    cla_ctl_if.slew   ctl
);
    logic [cla_pkg::SLEW_CNT_W-1:0] cnt;
    logic [cla_pkg::SLEW_CNT_W-1:0] next_cnt;
    logic [8:0]                     eff;
    logic [8:0]                     next_eff;
    logic                           tick;

    function automatic logic [cla_pkg::SLEW_CNT_W-1:0] interval(input logic [2:0] sel);
        interval = cla_pkg::SLEW_CNT_W'(cla_pkg::SLEW_BASE_CYC << (3'd7 - sel));
    endfunction

    always_comb begin
        tick     = (cnt >= interval(ctl.slew_sel) - 1'b1);
        next_cnt = tick ? '0 : cnt + 1'b1;
        next_eff = eff;
        if (tick && eff < ctl.target) begin
            next_eff = eff + 1'b1;
        end else if (tick && eff > ctl.target) begin
            next_eff = eff - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cnt <= '0;
            eff <= cla_pkg::RATE_RESET;
        end else begin
            cnt <= next_cnt;
            eff <= next_eff;
        end
    end

    assign ctl.effective = eff;

    sequence s_one_step;
        ##1 (eff == $past(eff) + 9'h001) or (eff == $past(eff) - 9'h001) or (eff == $past(eff));
    endsequence

    slew_step_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        1'b1 |-> s_one_step) else $error("Command moved by more than one step");
    slew_dir_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (tick && eff < ctl.target) |=> eff == $past(eff) + 9'h001)
        else $error("Command did not move toward target");
endmodule // cla_slew

// ===== verilog/cla_advance.sv
// Advance time: fixed setting, or setting scaled by (drive - back-EMF) / drive
// Assumes synchronous active-high reset; result in whole clock cycles, rounded down
`timescale 1ns/1ns
module cla_advance (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    // Advance carrier
    cla_ctl_if.adv    ctl
);
    logic [31:0] setting_half;
    logic [31:0] setting;
    logic [31:0] scaled;
    logic [17:0] adv;
    logic [17:0] next_adv;

    always_comb begin
        setting_half = cla_pkg::ADV_UNIT_HALF * (32'(ctl.adv_code[3:0]) << ctl.adv_code[6:4]);
        setting      = setting_half >> 1;
        scaled       = 32'h0;
        if (ctl.effective != 9'h000 && ctl.bemf_amp < ctl.effective) begin
            scaled = (setting * 32'(ctl.effective - ctl.bemf_amp)) / 32'(ctl.effective);
        end
        next_adv = ctl.adv_mode ? scaled[17:0] : setting[17:0];
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            adv <= '0;
        end else begin
            adv <= next_adv;
        end
    end

    assign ctl.adv_cycles = adv;

    adv_fixed_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!ctl.adv_mode && ctl.adv_code == 7'h01) |=> adv == 18'h0003e)
        else $error("Fixed advance for one step is not 62 cycles");
    adv_bound_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (ctl.adv_mode && ctl.bemf_amp >= ctl.effective) |=> adv == 18'h00000)
        else $error("Scaled advance not zero when back-EMF reaches drive");
    adv_max_a : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!ctl.adv_mode && ctl.adv_code == 7'h7f) |=> adv == 18'h1d4c0)
        else $error("Largest fixed advance is not 120000 cycles");
endmodule // cla_advance

// ===== verif/cla_motor_model.sv
// Motor side model: phase current, back-EMF, overcurrent comparator and rate pin
// Assumes bench settings change after a rising edge; outputs follow one edge later
`timescale 1ns/1ns
module cla_motor_model (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    // Settings from the bench
    input  wire logic [11:0] current_set_i,
    input  wire logic [8:0]  bemf_set_i,
    input  wire logic        oc_set_i,
    input  wire logic [8:0]  level_set_i,
    input  wire logic [9:0]  duty_set_i,
    // Motor and pin side
    output logic      [11:0] phase_current_o,
    output logic      [8:0]  bemf_amp_o,
    output logic             overcurrent_o,
    output logic      [8:0]  rate_level_o,
    output logic             rate_pulse_o
);
    logic [8:0] pwm_cnt;

    // Pulse pin high for the first duty_set_i cycles of every 512
    always_ff @(posedge ref_clk_i) begin
        pwm_cnt         <= sys_rst_i ? 9'h000 : pwm_cnt + 9'h001;
        phase_current_o <= current_set_i;
        bemf_amp_o      <= bemf_set_i;
        overcurrent_o   <= oc_set_i;
        rate_level_o    <= level_set_i;
        rate_pulse_o    <= ({1'b0, pwm_cnt} < duty_set_i);
    end
endmodule // cla_motor_model

// ===== verif/cla_tb_top.sv
// Testbench: register bus, rate source, slew, feedback, advance, overcurrent
// Assumes cla_top as a zero-wait AHB-Lite slave with hready looped back
`timescale 1ns/1ns
module cla_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        hsel_i    = 1'b0;
    logic [31:0] haddr_i   = 32'h0;
    logic [1:0]  htrans_i  = 2'b00;
    logic        hwrite_i  = 1'b0;
    logic [2:0]  hsize_i   = 3'b010;
    logic [31:0] hwdata_i  = 32'h0;
    logic [11:0] cur_set   = 12'h000;
    logic [8:0]  bemf_set  = 9'h000;
    logic        oc_set    = 1'b0;
    logic [8:0]  lvl_set   = 9'h000;
    logic [9:0]  duty_set  = 10'h000;
    logic        hreadyout_o, hresp_o, rate_pulse_i, overcurrent_i, drive_enable_o;
    logic [31:0] hrdata_o;
    logic [8:0]  rate_level_i, bemf_amp_i, drive_amplitude_o;
    logic [11:0] phase_current_i, loop_feedback_o;
    logic [17:0] advance_cycles_o;
    logic [31:0] x;
    int          n_errors  = 0;
    int          tests_run = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    cla_top #(.FB_W(12)) dut_u (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .rate_level_i(rate_level_i), .rate_pulse_i(rate_pulse_i),
        .phase_current_i(phase_current_i), .bemf_amp_i(bemf_amp_i),
        .overcurrent_i(overcurrent_i), .drive_amplitude_o(drive_amplitude_o),
        .advance_cycles_o(advance_cycles_o), .loop_feedback_o(loop_feedback_o),
        .drive_enable_o(drive_enable_o));

    cla_motor_model motor_u (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .current_set_i(cur_set),
        .bemf_set_i(bemf_set), .oc_set_i(oc_set), .level_set_i(lvl_set),
        .duty_set_i(duty_set), .phase_current_o(phase_current_i), .bemf_amp_o(bemf_amp_i),
        .overcurrent_o(overcurrent_i), .rate_level_o(rate_level_i),
        .rate_pulse_o(rate_pulse_i));

    task automatic give_verdict();
        $display("counts: tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Wait for hready high at a rising edge, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 64);
        if (hreadyout_o !== 1'b1) begin
            chk("hready", 32'h1, {31'h0, hreadyout_o});
            give_verdict();
        end
    endtask

    // One single word transfer; entered right after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel_i   <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i  <= {24'h0, a};
        hwrite_i <= wr;
        wait_rdy();
        htrans_i <= 2'b00;
        hsel_i   <= 1'b0;
        hwdata_i <= wd;
        wait_rdy();
        rd = hrdata_o;
        chk("hresp", 32'h0, {31'h0, hresp_o});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a);
        ahb(1'b0, a, 32'h0, x);
    endtask

    function automatic logic [31:0] ctrl(input logic h, input logic m, input logic am,
                                         input logic [2:0] s, input logic [1:0] at);
        return {24'h0, at, s, am, m, h};
    endfunction

    // Walk the drive toward goal, sampling once per selected step interval
    task automatic ramp(input logic [8:0] goal, input int per);
        logic [8:0] prev;
        int         big;
        int         n;
        big  = 0;
        n    = 0;
        prev = drive_amplitude_o;
        while (drive_amplitude_o !== goal && n < 600) begin
            cyc(per);
            if ({1'b0, drive_amplitude_o} > {1'b0, prev} + 10'h001 ||
                {1'b0, prev} > {1'b0, drive_amplitude_o} + 10'h001) begin
                big++;
            end
            prev = drive_amplitude_o;
            n++;
        end
        chk("slew oversize steps", 32'h0, big);
        chk("drive amplitude", {23'h0, goal}, {23'h0, drive_amplitude_o});
        if (drive_amplitude_o !== goal) begin
            give_verdict();
        end
    endtask

    task automatic t_reset();
        rd(cla_pkg::OFS_CTRL);
        chk("ctrl reset", 32'h0, x);
        rd(cla_pkg::OFS_STATUS);
        chk("status reset", 32'h0, x);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40);
        chk("unmapped read", 32'h0, x);
        chk("drive enable", 32'h1, {31'h0, drive_enable_o});
        $display("test reset done");
    endtask

    task automatic t_pin();
        lvl_set  <= 9'h0a5;
        duty_set <= 10'h080;
        wr(cla_pkg::OFS_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'h7, 2'h0));
        cyc(4);
        rd(cla_pkg::OFS_STATUS);
        chk("level target", 32'h0a5, {23'h0, x[24:16]});
        wr(cla_pkg::OFS_CTRL, ctrl(1'b0, 1'b1, 1'b0, 3'h7, 2'h0));
        cyc(1100);
        rd(cla_pkg::OFS_STATUS);
        chk("pulse target", 32'h080, {23'h0, x[24:16]});
        lvl_set <= 9'h155;
        wr(cla_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 3'h7, 2'h0));
        cyc(4);
        rd(cla_pkg::OFS_STATUS);
        chk("host target", 32'h000, {23'h0, x[24:16]});
        $display("test pin done");
    endtask

    task automatic t_host();
        wr(cla_pkg::OFS_RATE_HIGH, 32'h1);
        cyc(4);
        rd(cla_pkg::OFS_STATUS);
        chk("target after high", 32'h000, {23'h0, x[24:16]});
        wr(cla_pkg::OFS_RATE_LOW, 32'hff);
        cyc(2);
        rd(cla_pkg::OFS_STATUS);
        chk("target after low", 32'h1ff, {23'h0, x[24:16]});
        rd(cla_pkg::OFS_RATE_HIGH);
        chk("rate high readback", 32'h1, x);
        rd(cla_pkg::OFS_RATE_LOW);
        chk("rate low readback", 32'hff, x);
        ramp(cla_pkg::CMD_FULL_SCALE, 16);
        rd(cla_pkg::OFS_STATUS);
        chk("status effective", 32'h1ff, {23'h0, x[8:0]});
        wr(cla_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 3'h6, 2'h0));
        wr(cla_pkg::OFS_RATE_LOW, 32'h00);
        ramp(9'h100, 32);
        $display("test host done");
    endtask

    task automatic t_fb();
        logic [1:0] a;
        cur_set <= 12'hc00;
        for (int i = 0; i < 4; i++) begin
            a = i[1:0];
            wr(cla_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 3'h7, a));
            cyc(3);
            chk("feedback", {20'h0, 12'hc00 >> a}, {20'h0, loop_feedback_o});
        end
        $display("test feedback done");
    endtask

    task automatic t_adv();
        logic [6:0]  codes [4] = '{7'h01, 7'h2a, 7'h58, 7'h7f};
        logic [31:0] e;
        wr(cla_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0, 3'h7, 2'h0));
        foreach (codes[i]) begin
            e = (32'd125 * ({28'h0, codes[i][3:0]} << codes[i][6:4])) / 32'd2;
            wr(cla_pkg::OFS_ADV_CODE, {25'h0, codes[i]});
            cyc(3);
            chk("advance fixed", e, {14'h0, advance_cycles_o});
            rd(cla_pkg::OFS_ADV_STATUS);
            chk("advance status", e, x);
            rd(cla_pkg::OFS_ADV_CODE);
            chk("advance code readback", {25'h0, codes[i]}, x);
        end
        bemf_set <= 9'h040;
        wr(cla_pkg::OFS_CTRL, ctrl(1'b1, 1'b0, 1'b1, 3'h7, 2'h0));
        cyc(4);
        chk("advance scaled", e * 32'd192 / 32'd256, {14'h0, advance_cycles_o});
        bemf_set <= 9'h12c;
        cyc(4);
        chk("advance bemf high", 32'h0, {14'h0, advance_cycles_o});
        $display("test advance done");
    endtask

    task automatic t_oc();
        wr(cla_pkg::OFS_CTRL, 32'hff);
        oc_set <= 1'b1;
        cyc(3);
        chk("drive enable oc", 32'h0, {31'h0, drive_enable_o});
        rd(cla_pkg::OFS_PROT_STATUS);
        chk("prot status", 32'h1, x);
        oc_set <= 1'b0;
        cyc(3);
        chk("drive enable clear", 32'h1, {31'h0, drive_enable_o});
        $display("test overcurrent done");
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset();
        t_pin();
        t_host();
        t_fb();
        t_adv();
        t_oc();
        give_verdict();
    end
endmodule // cla_tb_top
